// ---- verilog/acrb_pkg.sv ----
/*
  acrb_pkg: constants and carrier types for the converter configuration
  register bank. Assumes a byte-addressed register port in the clock_i
  domain, as presented by the serial frame decoder.
*/
package acrb_pkg;
  // byte addresses of the configuration registers (base of each word)
  localparam logic [5:0] ADDR_CHAIN_IDENTITY  = 6'h00;
  localparam logic [5:0] ADDR_RESET_POWER     = 6'h04;
  localparam logic [5:0] ADDR_SERIAL_PROTOCOL = 6'h08;
  localparam logic [5:0] ADDR_SERIAL_OUTPUT   = 6'h0C;
  localparam logic [5:0] ADDR_OUTPUT_WORD     = 6'h10;
  localparam logic [5:0] ADDR_INPUT_RANGE     = 6'h14;
  localparam logic [5:0] ADDR_ALARM_FLAGS     = 6'h20;
  localparam logic [5:0] ADDR_ALARM_HIGH      = 6'h24;
  localparam logic [5:0] ADDR_ALARM_LOW       = 6'h28;
  // writable byte of the identity word
  localparam logic [5:0] ADDR_CHAIN_BYTE      = 6'h02;
  // unlock sequence: byte address and key value
  localparam logic [5:0] ADDR_UNLOCK_KEY      = 6'h05;
  localparam logic [7:0] UNLOCK_KEY_VALUE     = 8'h69;
  // field positions
  localparam int CHAIN_ADDR_LSB   = 16;
  localparam int KEY_LSB          = 8;
  localparam int SUPPLY_ALARM_BIT = 5;
  localparam int INPUT_ALARM_BIT  = 4;
  localparam int RESET_CLASS_BIT  = 2;
  localparam int NAP_BIT          = 1;
  localparam int POWER_DOWN_BIT   = 0;
  localparam int PROTOCOL_LSB     = 0;
  // writable bits of the power control byte
  localparam logic [5:0] POWER_WRITE_MASK = 6'h37;
  // reset values
  localparam logic [3:0] CHAIN_ADDR_RESET = 4'h1;
  localparam logic [7:0] KEY_RESET        = 8'h00;
  localparam logic [1:0] PROTOCOL_RESET   = 2'h0;
  localparam logic [7:0] GENERIC_RESET    = 8'h00;
  localparam logic [5:0] POWER_FULL_RESET = 6'h00;
  localparam logic [5:0] POWER_APP_RESET  = 6'h04;
  // words held as plain storage here; their fields belong to other blocks
  localparam int GENERIC_WORDS = 6;

  // spi clock mode selected by the protocol field
  typedef struct packed {
    logic polarity;
    logic phase;
  } acrb_spi_mode_t;

  // byte access request from the frame decoder
  typedef struct packed {
    logic       wr_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } acrb_req_t;

  // power and alarm controls towards the converter core
  typedef struct packed {
    logic supply_alarm_disable;
    logic input_alarm_disable;
    logic reset_pin_class;
    logic nap_enable;
    logic power_down;
  } acrb_ctrl_t;
endpackage : acrb_pkg

// ---- verilog/acrb_bank.sv ----
/*
  acrb_bank: configuration register bank of the sampling converter.
  Assumes the serial frame decoder delivers one byte access per cycle
  on clock_i, write only for frames of at least 32 serial clocks, and
  switches to a new spi mode only after the frame that wrote it ends.
*/
// Overview of operation
// - nine 32-bit words at 00h-14h and 20h-28h, four bytes each.
// - byte n of a word holds bits 8n+7..8n, at base plus n.
// - reserved bits are read-only and always read back as zero.
// - chain address at identity bits 19-16, read-write, resets to 0001b.
// - key at bits 15-8 resets 00h; bits 5-0 writable only with key 69h.
// - bit 5 set disables the supply alarm; resets zero.
// - bit 4 set disables the input alarm; resets zero.
// - bit 2 clear gives full reset from pin; set clears user modes only.
// - once set, reset class stays set until power cycle.
// - bit 1 set allows nap when convert line high after conversion.
// - bit 0 set powers the converter down; clear keeps it active.
// - protocol bits 1-0 pick spi polarity and phase 00,01,10,11.
// - the chosen protocol governs both read and write frames.
// - protocol field read-write, resets 00b; other bits reserved.
// - after any reset mode 0,0; new mode applies from next frame.
`timescale 1ns/1ps
module acrb_bank (
  // clock and resets
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  input  wire logic                   power_on_i,
  // byte access port
  input  wire acrb_pkg::acrb_req_t    req_i,
  output logic [7:0]                  rdata_o,
  // converter core controls
  input  wire logic                   convert_start_select_i,
  input  wire logic                   conversion_done_i,
  output acrb_pkg::acrb_ctrl_t        ctrl_o,
  output logic                        nap_request_o,
  output logic [3:0]                  chain_address_o,
  output acrb_pkg::acrb_spi_mode_t    spi_mode_o,
  output logic [1:0]                  serial_protocol_select_o,
  output logic                        full_reset_o
);

  typedef enum {
    ACRB_ACTIVE,
    ACRB_NAP
  } acrb_nap_t;

  // register state
  logic [3:0] chain_addr_r,  chain_addr_nxt;
  logic [7:0] unlock_key_r,  unlock_key_nxt;
  logic [5:0] power_bits_r,  power_bits_nxt;
  logic       class_sticky_r, class_sticky_nxt;
  logic [1:0] protocol_r,    protocol_nxt;
  logic [7:0] generic_r [acrb_pkg::GENERIC_WORDS*4];
  logic [7:0] generic_nxt [acrb_pkg::GENERIC_WORDS*4];
  acrb_nap_t  nap_r,         nap_nxt;
  logic [7:0] rdata_r,       rdata_nxt;

  // decode helpers
  logic [5:0] word_base;
  logic [1:0] byte_sel;
  logic       pin_full;
  logic       pin_app;
  logic       unlocked;
  logic       gen_hit;
  logic [4:0] gen_idx;
  logic       wr_identity;
  logic       wr_key;
  logic       wr_power;
  logic       wr_protocol;
  logic       wr_generic;
  logic       user_clear;

  // byte address split into word base and byte lane
  assign word_base = {req_i.addr[5:2], 2'b00};
  assign byte_sel  = req_i.addr[1:0];
  // pin reset class: full unless application class was latched
  assign pin_app   = rst_i && class_sticky_r;
  assign pin_full  = power_on_i || (rst_i && !class_sticky_r);
  assign unlocked  = (unlock_key_r == acrb_pkg::UNLOCK_KEY_VALUE);

  // write strobes, one for each writable byte and one shared by all storage words
  assign wr_identity = req_i.wr_en
                       && req_i.addr == acrb_pkg::ADDR_CHAIN_BYTE;
  assign wr_key      = req_i.wr_en
                       && req_i.addr == acrb_pkg::ADDR_UNLOCK_KEY;
  assign wr_power    = req_i.wr_en
                       && req_i.addr == acrb_pkg::ADDR_RESET_POWER;
  assign wr_protocol = req_i.wr_en
                       && req_i.addr == acrb_pkg::ADDR_SERIAL_PROTOCOL;
  assign wr_generic  = req_i.wr_en && gen_hit;
  // both reset classes clear the user fields
  assign user_clear  = pin_full || pin_app;

  // map of plain-storage words onto the generic array
  always_comb begin
    gen_hit = 1'b1;
    gen_idx = 5'h00;
    case (word_base)
      acrb_pkg::ADDR_SERIAL_OUTPUT: gen_idx = {3'h0, byte_sel};
      acrb_pkg::ADDR_OUTPUT_WORD:   gen_idx = {3'h1, byte_sel};
      acrb_pkg::ADDR_INPUT_RANGE:   gen_idx = {3'h2, byte_sel};
      acrb_pkg::ADDR_ALARM_FLAGS:   gen_idx = {3'h3, byte_sel};
      acrb_pkg::ADDR_ALARM_HIGH:    gen_idx = {3'h4, byte_sel};
      acrb_pkg::ADDR_ALARM_LOW:     gen_idx = {3'h5, byte_sel};
      default:                      gen_hit = 1'b0;
    endcase
  end

  // next chain address: only bits 3-0 of identity byte 2 are writable
  always_comb begin
    chain_addr_nxt = chain_addr_r;
    if (wr_identity) begin
      chain_addr_nxt = req_i.wdata[3:0];
    end
  end

  // chain address register, back to 0001b after either reset class
  always_ff @(posedge clock_i) begin
    if (user_clear) begin
      chain_addr_r <= acrb_pkg::CHAIN_ADDR_RESET;
    end else begin
      chain_addr_r <= chain_addr_nxt;
    end
  end

  // next key: any byte written at base plus one
  always_comb begin
    unlock_key_nxt = unlock_key_r;
    if (wr_key) begin
      unlock_key_nxt = req_i.wdata;
    end
  end

  // key register, locked again by either reset class
  always_ff @(posedge clock_i) begin
    if (user_clear) begin
      unlock_key_r <= acrb_pkg::KEY_RESET;
    end else begin
      unlock_key_r <= unlock_key_nxt;
    end
  end

  // next power bits: locked writes dropped, bits 7-6 and 3 ignored
  always_comb begin
    power_bits_nxt = power_bits_r;
    if (wr_power && unlocked) begin
      power_bits_nxt = req_i.wdata[5:0]
                       & acrb_pkg::POWER_WRITE_MASK;
      // a latched class bit cannot be written back to zero
      power_bits_nxt[acrb_pkg::RESET_CLASS_BIT] =
        req_i.wdata[acrb_pkg::RESET_CLASS_BIT] || class_sticky_r;
    end
  end

  // power bits: application reset keeps only the class bit
  always_ff @(posedge clock_i) begin
    if (pin_full) begin
      power_bits_r <= acrb_pkg::POWER_FULL_RESET;
    end else if (pin_app) begin
      power_bits_r <= acrb_pkg::POWER_APP_RESET;
    end else begin
      power_bits_r <= power_bits_nxt;
    end
  end

  // next reset class: latched by an unlocked write of bit 2
  always_comb begin
    class_sticky_nxt = class_sticky_r;
    if (wr_power && unlocked
        && req_i.wdata[acrb_pkg::RESET_CLASS_BIT]) begin
      class_sticky_nxt = 1'b1;
    end
  end

  // next protocol: only bits 1-0 of byte 0
  always_comb begin
    protocol_nxt = protocol_r;
    if (wr_protocol) begin
      protocol_nxt = req_i.wdata[1:0];
    end
  end

  // protocol register: mode 0,0 again after either reset class
  always_ff @(posedge clock_i) begin
    if (user_clear) begin
      protocol_r <= acrb_pkg::PROTOCOL_RESET;
    end else begin
      protocol_r <= protocol_nxt;
    end
  end

  // next storage bytes: all eight bits of a plain word are kept
  always_comb begin
    generic_nxt = generic_r;
    if (wr_generic) begin
      generic_nxt[gen_idx] = req_i.wdata;
    end
  end

  // storage bytes, cleared by either reset class
  always_ff @(posedge clock_i) begin
    if (user_clear) begin
      for (int i = 0; i < acrb_pkg::GENERIC_WORDS*4; i++) begin
        generic_r[i] <= acrb_pkg::GENERIC_RESET;
      end
    end else begin
      generic_r <= generic_nxt;
    end
  end

  // sticky reset class survives everything but power-on
  always_ff @(posedge clock_i) begin
    if (power_on_i) begin
      class_sticky_r <= 1'b0;
    end else begin
      class_sticky_r <= class_sticky_nxt;
    end
  end

  // nap tracking: enter after conversion with convert line high
  always_comb begin
    nap_nxt = nap_r;
    case (nap_r)
      ACRB_ACTIVE: begin
        if (power_bits_r[acrb_pkg::NAP_BIT] && conversion_done_i
            && convert_start_select_i) begin
          nap_nxt = ACRB_NAP;
        end
      end
      ACRB_NAP: begin
        if (!convert_start_select_i
            || !power_bits_r[acrb_pkg::NAP_BIT]) begin
          nap_nxt = ACRB_ACTIVE;
        end
      end
      default: nap_nxt = ACRB_ACTIVE;
    endcase
  end

  // nap state register, active after any reset
  always_ff @(posedge clock_i) begin
    if (rst_i || power_on_i) begin
      nap_r <= ACRB_ACTIVE;
    end else begin
      nap_r <= nap_nxt;
    end
  end

  // read mux: reserved bits return zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (req_i.addr)
      acrb_pkg::ADDR_CHAIN_BYTE:
        rdata_nxt = {4'h0, chain_addr_r};
      acrb_pkg::ADDR_RESET_POWER:
        rdata_nxt = {2'b00, power_bits_r};
      acrb_pkg::ADDR_UNLOCK_KEY:
        rdata_nxt = unlock_key_r;
      acrb_pkg::ADDR_SERIAL_PROTOCOL:
        rdata_nxt = {6'h00, protocol_r};
      default: begin
        if (gen_hit) begin
          rdata_nxt = generic_r[gen_idx];
        end
      end
    endcase
  end

  // read data register, one cycle behind the address
  always_ff @(posedge clock_i) begin
    if (rst_i || power_on_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs towards the core and the serial front end
  assign rdata_o                  = rdata_r;
  assign chain_address_o          = chain_addr_r;
  assign serial_protocol_select_o = protocol_r;
  assign spi_mode_o = '{
    polarity: protocol_r[1],
    phase:    protocol_r[0]
  };
  assign ctrl_o = '{
    supply_alarm_disable: power_bits_r[acrb_pkg::SUPPLY_ALARM_BIT],
    input_alarm_disable:  power_bits_r[acrb_pkg::INPUT_ALARM_BIT],
    reset_pin_class:      class_sticky_r,
    nap_enable:           power_bits_r[acrb_pkg::NAP_BIT],
    power_down:           power_bits_r[acrb_pkg::POWER_DOWN_BIT]
  };
  // nap state and pin reset class towards the core
  assign nap_request_o = (nap_r == ACRB_NAP);
  assign full_reset_o  = pin_full;

endmodule : acrb_bank

// ---- bench/acrb_host.sv ----
/* acrb_host: host side model of the byte access port.
   Assumes one byte access per decoded frame on clock_i. */
`timescale 1ns/1ps
module acrb_host (
  // clock
  input  wire logic          clock_i,
  // byte access port
  output acrb_pkg::acrb_req_t req_o,
  input  wire logic [7:0]    rdata_i
);
  initial req_o = '0;
  // one byte write per full frame of 32 or more clocks, strobe one cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_o <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge clock_i);
    req_o.wr_en <= 1'b0;
  endtask : wr
  // read: address held until the registered answer has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_i);
    req_o <= '{wr_en: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    #1 d = rdata_i;
  endtask : rd
endmodule : acrb_host

// ---- bench/acrb_bank_assertions.sv ----
/* acrb_bank_assertions: port checks of the register bank.
   Bound to acrb_bank, sees its ports only. */
`timescale 1ns/1ps
module acrb_bank_assertions (
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  // byte port
  input wire acrb_pkg::acrb_req_t req_i,
  input wire logic [7:0] rdata_o,
  // controls
  input wire acrb_pkg::acrb_ctrl_t ctrl_o,
  input wire logic nap_request_o,
  input wire logic [3:0] chain_address_o,
  input wire acrb_pkg::acrb_spi_mode_t spi_mode_o,
  input wire logic [1:0] serial_protocol_select_o,
  input wire logic full_reset_o
);
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || power_on_i);
  // copy of the unlock key
  always_comb begin
    key_nxt = key_r;
    if (req_i.wr_en && req_i.addr == 6'h05) key_nxt = req_i.wdata;
  end
  always_ff @(posedge clock_i) begin
    key_r <= (rst_i || power_on_i) ? 8'h00 : key_nxt;
  end
  // key write, idle cycle, power control write
  sequence s_unlock;
    req_i.wr_en && req_i.addr == 6'h05 && req_i.wdata == 8'h69;
  endsequence
  sequence s_ctrl_wr;
    req_i.wr_en && req_i.addr == 6'h04;
  endsequence
  a_unlocked_write: assert property (
    s_unlock ##1 !req_i.wr_en ##1 s_ctrl_wr |=>
    ctrl_o.power_down == $past(req_i.wdata[0]) &&
    ctrl_o.supply_alarm_disable == $past(req_i.wdata[5]))
    else $error("unlocked power control write lost");
  a_locked_write: assert property (
    s_ctrl_wr ##0 key_r != 8'h69 |=> $stable(ctrl_o))
    else $error("locked power control write taken");
  a_class_sticky: assert property (
    ctrl_o.reset_pin_class |=> ctrl_o.reset_pin_class)
    else $error("reset class bit cleared");
  a_full_reset: assert property (disable iff (1'b0)
    full_reset_o == (power_on_i || (rst_i && !ctrl_o.reset_pin_class)))
    else $error("full reset output wrong");
  a_app_reset: assert property (disable iff (1'b0)
    rst_i && !power_on_i && ctrl_o.reset_pin_class |=> ctrl_o == 5'h04)
    else $error("application reset wrong");
  a_power_on_init: assert property (disable iff (1'b0)
    power_on_i |=> chain_address_o == 4'h1 && ctrl_o == 5'h00 &&
    serial_protocol_select_o == 2'h0 && spi_mode_o == 2'h0)
    else $error("power on values wrong");
  a_chain_write: assert property (
    req_i.wr_en && req_i.addr == 6'h02 |=>
    chain_address_o == $past(req_i.wdata[3:0]))
    else $error("chain address write lost");
  a_proto_write: assert property (
    req_i.wr_en && req_i.addr == 6'h08 |=>
    spi_mode_o == $past(req_i.wdata[1:0]) &&
    serial_protocol_select_o == $past(req_i.wdata[1:0]))
    else $error("protocol write lost");
  a_reserved_read: assert property (
    req_i.addr inside {6'h00, 6'h01, 6'h03, 6'h09, 6'h18, 6'h2C} |=>
    rdata_o == 8'h00) else $error("reserved byte not zero");
  a_nap_entry: assert property (
    $rose(nap_request_o) |-> ctrl_o.nap_enable)
    else $error("nap without enable");
endmodule : acrb_bank_assertions

// ---- bench/tb_acrb_bank.sv ----
/* tb_acrb_bank: random and directed checks of the register bank.
   Assumes the host model on the byte port and a 125 MHz clock. */
`timescale 1ns/1ps
module tb_acrb_bank;
  logic clock_i, rst_i, power_on_i, conv, done, nap, full_rst;
  logic [7:0] rdata;
  logic [3:0] chain;
  logic [1:0] proto;
  acrb_pkg::acrb_req_t req;
  acrb_pkg::acrb_ctrl_t ctrl;
  acrb_pkg::acrb_spi_mode_t mode;
  logic [7:0] mdl [64];
  int num_errors = 0;
  int samples_checked = 0;
  acrb_bank i_acrb_bank (.clock_i(clock_i), .rst_i(rst_i),
    .power_on_i(power_on_i), .req_i(req), .rdata_o(rdata),
    .convert_start_select_i(conv), .conversion_done_i(done),
    .ctrl_o(ctrl), .nap_request_o(nap), .chain_address_o(chain),
    .spi_mode_o(mode), .serial_protocol_select_o(proto),
    .full_reset_o(full_rst));
  acrb_host i_acrb_host (.clock_i(clock_i), .req_o(req), .rdata_i(rdata));
  // compare one byte result
  task automatic chk8(input logic [7:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // writable bits of each byte address
  function automatic logic [7:0] wmask(input logic [5:0] a);
    if (a == 6'h02) return 8'h0F;
    if (a == 6'h04) return 8'h37;
    if (a == 6'h05) return 8'hFF;
    if (a == 6'h08) return 8'h03;
    if (a inside {[6'h0C:6'h17], [6'h20:6'h2B]}) return 8'hFF;
    return 8'h00;
  endfunction : wmask
  // write on the bank and on the expected copy, class bit sticky
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_acrb_host.wr(a, d);
    if (a != 6'h04 || mdl[5] == 8'h69)
      mdl[a] = (d & wmask(a)) | (a == 6'h04 ? mdl[4] & 8'h04 : 8'h00);
  endtask : wr
  task automatic ctl(input logic [7:0] d);
    wr(6'h05, 8'h69);
    wr(6'h04, d);
  endtask : ctl
  // expected state after reset; application reset keeps the class bit
  task automatic mrst(input logic keep);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[2] = 8'h01;
    if (keep) mdl[4] = 8'h04;
  endtask : mrst
  // read every byte and compare the ctrl, chain and spi mode outputs with the expected copy
  task automatic check_all(input string name);
    logic [7:0] v;
    logic [7:0] m;
    for (int a = 0; a < 64; a++) begin
      i_acrb_host.rd(6'(a), v);
      chk8(v, mdl[a], "read back");
    end
    m = mdl[4];
    chk8({3'h0, ctrl}, {3'h0, m[5:4], m[2:0]}, "ctrl");
    chk8({4'h0, chain}, {4'h0, mdl[2][3:0]}, "chain");
    chk8({4'h0, mode, proto}, {4'h0, {2{mdl[8][1:0]}}}, "mode");
    $display("test %s done", name);
  endtask : check_all
  // one-edge reset pulse with the full reset output checked
  task automatic pulse(input logic po, input logic [7:0] fr);
    @(posedge clock_i);
    rst_i <= ~po;
    power_on_i <= po;
    #1 chk8({7'h0, full_rst}, fr, "full reset");
    @(posedge clock_i);
    rst_i <= 1'b0;
    power_on_i <= 1'b0;
  endtask : pulse
  // convert line high across a finished conversion, then low
  task automatic nap_try(input logic [7:0] exp);
    @(posedge clock_i);
    conv <= 1'b1;
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk8({7'h0, nap}, exp, "nap entry");
    @(posedge clock_i);
    conv <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk8({7'h0, nap}, 8'h00, "nap exit");
  endtask : nap_try
  // clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    power_on_i = 1'b1;
    conv = 1'b0;
    done = 1'b0;
    void'($urandom(35));
    mrst(1'b0);
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    power_on_i <= 1'b0;
    check_all("reset");
    repeat (80) begin
      if ($urandom_range(3) == 0) ctl(8'($urandom));
      else wr(6'($urandom_range(63)), 8'($urandom));
    end
    check_all("random");
    wr(6'h05, 8'h00);
    wr(6'h04, 8'h3F);
    check_all("locked");
    for (int i = 0; i < 4; i++) begin
      wr(6'h08, 8'hFC | 8'(i));
      @(posedge clock_i);
      #1 chk8({6'h0, mode}, 8'(i), "spi mode");
    end
    $display("test spi mode done");
    pulse(1'b1, 8'h01);
    mrst(1'b0);
    ctl(8'h02);
    nap_try(8'h01);
    ctl(8'h00);
    nap_try(8'h00);
    $display("test nap done");
    ctl(8'h33);
    pulse(1'b0, 8'h01);
    mrst(1'b0);
    check_all("pin full");
    ctl(8'h37);
    pulse(1'b0, 8'h00);
    mrst(1'b1);
    ctl(8'h00);
    check_all("pin app");
    pulse(1'b1, 8'h01);
    mrst(1'b0);
    check_all("power on");
    give_verdict();
  end
endmodule : tb_acrb_bank
bind acrb_bank acrb_bank_assertions i_acrb_bank_assertions (
  .clock_i(clock_i), .rst_i(rst_i), .power_on_i(power_on_i),
  .req_i(req_i), .rdata_o(rdata_o), .ctrl_o(ctrl_o),
  .nap_request_o(nap_request_o), .chain_address_o(chain_address_o),
  .spi_mode_o(spi_mode_o), .full_reset_o(full_reset_o),
  .serial_protocol_select_o(serial_protocol_select_o));
